/* File: rtl/thermo_link_pkg.sv */
package thermo_link_pkg;
   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_MHZ        = 125;
   localparam int CONV_MS        = 750;
   localparam int CONV_CYCLES_12 = CONV_MS * 1000 * CLK_MHZ;
   localparam int COPY_MS        = 10;
   localparam int COPY_CYCLES    = COPY_MS * 1000 * CLK_MHZ;
   localparam int SPU_MAX_US     = 10;
   localparam int SPU_MAX_CYCLES = SPU_MAX_US * CLK_MHZ;
   localparam int WAIT_US        = 1000;
   localparam int WAIT_CYCLES    = WAIT_US * CLK_MHZ;
   localparam logic [2:0] SLOT_DIV = 3'h4;

   // ==========================================================
   // Command bytes
   // ==========================================================
   localparam logic [7:0] CMD_CONVERT   = 8'h44;
   localparam logic [7:0] CMD_READ_PAD  = 8'hBE;
   localparam logic [7:0] CMD_WRITE_PAD = 8'h4E;
   localparam logic [7:0] CMD_COPY      = 8'h48;
   localparam logic [7:0] CMD_RECALL    = 8'hA7;
   localparam logic [7:0] CMD_POWER     = 8'hA6;
   localparam logic [7:0] ROM_READ      = 8'hA1;
   localparam logic [7:0] ROM_MATCH     = 8'hA2;
   localparam logic [7:0] ROM_SEARCH    = 8'hA3;
   localparam logic [7:0] ROM_SKIP      = 8'hA4;
   localparam logic [7:0] ROM_ALARM     = 8'hA5;

   // ==========================================================
   // Identity and reset values
   // ==========================================================
   // Arbitrary identity values
   localparam logic [7:0]  FAMILY_CODE = 8'h5A;
   localparam logic [47:0] SERIAL_NUM  = 48'h0123456789AB;
   localparam logic [7:0]  ROM_CHECK   = 8'h00;
   localparam logic [63:0] ROM_ID      = {ROM_CHECK, SERIAL_NUM, FAMILY_CODE};
   localparam logic [15:0] TEMP_RESET  = 16'h0550;
   localparam logic [7:0]  HIGH_TRIG_RESET = 8'h7F;
   localparam logic [7:0]  LOW_TRIG_RESET  = 8'h80;
   localparam logic [7:0]  CFG_RESET   = 8'h7F;
   localparam int          RES_LSB     = 5;
   localparam logic [7:0]  PAD_FILL    = 8'hFF;
   localparam logic [7:0]  PAD_CHECK   = 8'hFF;
   localparam logic [6:0]  PAD_LAST    = 7'h47;
   localparam logic [5:0]  ROM_LAST    = 6'h3F;

   // ==========================================================
   // Host operation codes (FIFO word bits 9:8)
   // ==========================================================
   localparam logic [1:0] OP_RESET = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ  = 2'h2;
   localparam logic [1:0] OP_WAIT  = 2'h3;
endpackage : thermo_link_pkg

/* File: rtl/thermo_link_if.sv */
`timescale 1ns/10ps
// ==========================================================
// Slot-level view of the open-drain data line
// ==========================================================
interface thermo_link_if;
   logic bus_reset;
   logic slot;
   logic master_bit;
   logic strong_pullup;
   logic dev_low;
   logic line;

   // Wired-AND: either party pulling low wins
   assign line = master_bit & ~dev_low;

   modport master (output bus_reset, output slot, output master_bit,
                   output strong_pullup, input line);
   modport sensor (input bus_reset, input slot, input line, output dev_low);
endinterface : thermo_link_if

/* File: rtl/thermo_sensor.sv */
`timescale 1ns/10ps
// Contract
// R1 - Function commands locked until identity sequence done
// R2 - Master opens with one identity command
// R3 - Six function commands accepted after identity
// R4 - All bytes travel least significant bit first
// R5 - Master strong pullup within 10 us
// R6 - Power query: bypass, query, read slots
// R7 - Power reply: 0 line-powered, 1 supply
// R8 - Line-powered: pullup through whole conversion
// R9 - Conversion result lands in scratchpad
// R10 - Alarm triggers one stored byte each
// R11 - Triggers written by command, read via scratchpad
// R12 - Configuration picks 9 to 12 bits
// R13 - 12-bit conversion done within 750 ms
// R14 - Identity commands act on 64-bit identity
// R15 - Supplied devices convert after bypass plus convert
// R16 - Trigger bytes keep any written value
// R17 - Codes 44, BE, 4E, 48
// R18 - Alarm flag refreshed after each conversion
// R19 - Bus reset returns to identity command wait
// R20 - Unknown function byte ignored until reset
module thermo_sensor #(
   parameter int CONV_CYCLES = thermo_link_pkg::CONV_CYCLES_12,
   parameter int COPY_CYCLES = thermo_link_pkg::COPY_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        ext_powered,
   input  wire logic [15:0] temp_sample,
   output logic             alarm,
   output logic             busy,
   thermo_link_if.sensor    lnk
);
   // ==========================================================
   // State
   // ==========================================================
   typedef enum logic [9:0] {
      S_IDLE    = 10'h001,
      S_ROM_CMD = 10'h002,
      S_TX_ROM  = 10'h004,
      S_MATCH   = 10'h008,
      S_SEARCH  = 10'h010,
      S_FN_CMD  = 10'h020,
      S_TX_PAD  = 10'h040,
      S_RX_PAD  = 10'h080,
      S_STATUS  = 10'h100,
      S_HALT    = 10'h200
   } sens_state_t;

   typedef struct packed {
      sens_state_t st;
      logic [7:0]  sh;
      logic [6:0]  idx;
      logic [1:0]  ph;
      logic        stat_pwr;
      logic        dev_low;
      logic [7:0]  high_alarm_trigger;
      logic [7:0]  low_alarm_trigger;
      logic [7:0]  cfg;
      logic [7:0]  nv_high_alarm_trigger;
      logic [7:0]  nv_low_alarm_trigger;
      logic [7:0]  nv_cfg;
      logic [15:0] temp;
      logic        alarm;
      logic [26:0] cnt;
      logic        conv;
      logic        copy;
   } sens_regs_t;

   localparam sens_regs_t RESET_VAL = '{
      st: S_IDLE, sh: 8'h00, idx: 7'h00, ph: 2'h0, stat_pwr: 1'b0, dev_low: 1'b0,
      high_alarm_trigger: thermo_link_pkg::HIGH_TRIG_RESET,
      low_alarm_trigger: thermo_link_pkg::LOW_TRIG_RESET,
      cfg: thermo_link_pkg::CFG_RESET,
      nv_high_alarm_trigger: thermo_link_pkg::HIGH_TRIG_RESET,
      nv_low_alarm_trigger: thermo_link_pkg::LOW_TRIG_RESET,
      nv_cfg: thermo_link_pkg::CFG_RESET,
      temp: thermo_link_pkg::TEMP_RESET, alarm: 1'b0, cnt: 27'h0000000,
      conv: 1'b0, copy: 1'b0};

   sens_regs_t  r;
   sens_regs_t  next_r;
   logic [71:0] pad;
   logic [1:0]  res_drop;
   logic [15:0] new_temp;
   logic [7:0]  byte_in;
   logic        b;
   logic        id_bit;

   assign alarm = r.alarm;
   assign busy  = r.conv | r.copy;

   // ==========================================================
   // Next-state logic
   // ==========================================================
   always_comb
   begin
      next_r   = r;
      b        = lnk.line;
      byte_in  = {b, r.sh[7:1]};  // [R4]
      id_bit   = thermo_link_pkg::ROM_ID[r.idx[5:0]];  // [R14]
      // Scratchpad as the master sees it, byte 0 first
      pad      = {thermo_link_pkg::PAD_CHECK, {3{thermo_link_pkg::PAD_FILL}},
                  r.cfg, r.low_alarm_trigger, r.high_alarm_trigger, r.temp};  // [R11]
      // Fewer bits means shorter conversion and zeroed low bits
      res_drop = 2'h3 - r.cfg[thermo_link_pkg::RES_LSB +: 2];  // [R12]
      new_temp = temp_sample & (16'hFFFF << res_drop);

      // Conversion and copy timer runs beside the link
      if (r.cnt != 27'h0000000)
         next_r.cnt = r.cnt - 27'h0000001;  // [R13]
      else if (r.conv)
      begin
         next_r.conv  = 1'b0;
         next_r.temp  = new_temp;  // [R9]
         // Only the integer byte is compared, sign included
         next_r.alarm = ($signed(new_temp[11:4]) > $signed(r.high_alarm_trigger)) ||
                        ($signed(new_temp[11:4]) < $signed(r.low_alarm_trigger));  // [R18]
      end
      else if (r.copy)
      begin
         next_r.copy   = 1'b0;
         next_r.nv_high_alarm_trigger = r.high_alarm_trigger;  // [R10] [R16]
         next_r.nv_low_alarm_trigger  = r.low_alarm_trigger;
         next_r.nv_cfg                = r.cfg;
      end

      if (lnk.slot)
      begin
         case (r.st)
            S_ROM_CMD:
            begin
               next_r.sh  = byte_in;
               next_r.idx = r.idx + 7'h01;
               if (r.idx[2:0] == 3'h7)
               begin
                  next_r.idx = 7'h00;
                  next_r.ph  = 2'h0;
                  // Only the five identity commands lead on [R2]
                  if (byte_in == thermo_link_pkg::ROM_READ)
                  begin
                     next_r.st      = S_TX_ROM;
                     next_r.dev_low = ~thermo_link_pkg::ROM_ID[0];
                  end
                  else if (byte_in == thermo_link_pkg::ROM_MATCH)
                     next_r.st = S_MATCH;
                  else if (byte_in == thermo_link_pkg::ROM_SKIP)
                     next_r.st = S_FN_CMD;
                  else if (byte_in == thermo_link_pkg::ROM_SEARCH ||
                           (byte_in == thermo_link_pkg::ROM_ALARM && r.alarm))
                  begin
                     next_r.st      = S_SEARCH;
                     next_r.dev_low = ~thermo_link_pkg::ROM_ID[0];
                  end
                  else
                     next_r.st = S_HALT;  // [R1]
               end
            end
            S_TX_ROM:
            begin
               next_r.idx     = r.idx + 7'h01;
               next_r.dev_low = ~thermo_link_pkg::ROM_ID[next_r.idx[5:0]];  // [R4]
               if (r.idx[5:0] == thermo_link_pkg::ROM_LAST)
               begin
                  next_r.st      = S_FN_CMD;
                  next_r.idx     = 7'h00;
                  next_r.dev_low = 1'b0;
               end
            end
            S_MATCH:
            begin
               next_r.idx = r.idx + 7'h01;
               if (b != id_bit)
                  next_r.st = S_HALT;  // [R14]
               else if (r.idx[5:0] == thermo_link_pkg::ROM_LAST)
               begin
                  next_r.st  = S_FN_CMD;
                  next_r.idx = 7'h00;
               end
            end
            S_SEARCH:
            begin
               // Bit, complement, then the master's choice
               next_r.ph = r.ph + 2'h1;
               if (r.ph == 2'h0)
                  next_r.dev_low = id_bit;
               else if (r.ph == 2'h1)
                  next_r.dev_low = 1'b0;
               else
               begin
                  next_r.ph      = 2'h0;
                  next_r.idx     = r.idx + 7'h01;
                  next_r.dev_low = ~thermo_link_pkg::ROM_ID[next_r.idx[5:0]];
                  if (b != id_bit)
                  begin
                     next_r.st      = S_HALT;
                     next_r.dev_low = 1'b0;
                  end
                  else if (r.idx[5:0] == thermo_link_pkg::ROM_LAST)
                  begin
                     next_r.st      = S_FN_CMD;
                     next_r.idx     = 7'h00;
                     next_r.dev_low = 1'b0;
                  end
               end
            end
            S_FN_CMD:
            begin
               next_r.sh  = byte_in;
               next_r.idx = r.idx + 7'h01;
               if (r.idx[2:0] == 3'h7)
               begin
                  next_r.idx      = 7'h00;
                  next_r.st       = S_STATUS;
                  next_r.stat_pwr = 1'b0;
                  // Function dispatch [R3] [R17]
                  if (byte_in == thermo_link_pkg::CMD_CONVERT)
                  begin
                     // Runs alike on both supplies [R15]
                     next_r.conv = 1'b1;
                     next_r.cnt  = 27'(CONV_CYCLES >> res_drop);  // [R13]
                  end
                  else if (byte_in == thermo_link_pkg::CMD_COPY)
                  begin
                     next_r.copy = 1'b1;
                     next_r.cnt  = 27'(COPY_CYCLES);
                  end
                  else if (byte_in == thermo_link_pkg::CMD_RECALL)
                  begin
                     next_r.high_alarm_trigger = r.nv_high_alarm_trigger;
                     next_r.low_alarm_trigger  = r.nv_low_alarm_trigger;
                     next_r.cfg                = r.nv_cfg;
                  end
                  else if (byte_in == thermo_link_pkg::CMD_POWER)
                     next_r.stat_pwr = 1'b1;  // [R6]
                  else if (byte_in == thermo_link_pkg::CMD_READ_PAD)
                  begin
                     next_r.st      = S_TX_PAD;
                     next_r.dev_low = ~pad[0];
                  end
                  else if (byte_in == thermo_link_pkg::CMD_WRITE_PAD)
                     next_r.st = S_RX_PAD;
                  else
                     next_r.st = S_HALT;  // [R20]
               end
            end
            S_TX_PAD:
            begin
               // Past the last byte the line is released
               next_r.dev_low = 1'b0;
               if (r.idx != thermo_link_pkg::PAD_LAST)
               begin
                  next_r.idx     = r.idx + 7'h01;
                  next_r.dev_low = ~pad[next_r.idx];  // [R4] [R9]
               end
            end
            S_RX_PAD:
            begin
               next_r.sh  = byte_in;
               next_r.idx = r.idx + 7'h01;
               if (r.idx[2:0] == 3'h7)
               begin
                  // Order: high trigger, low trigger, configuration
                  if (r.idx[4:3] == 2'h0)
                     next_r.high_alarm_trigger = byte_in;  // [R11] [R16]
                  else if (r.idx[4:3] == 2'h1)
                     next_r.low_alarm_trigger = byte_in;
                  else
                  begin
                     next_r.cfg = byte_in;  // [R12]
                     next_r.st  = S_HALT;
                  end
               end
            end
            default:
               next_r.st = r.st;
         endcase
      end

      // Status reply: supply kind or busy (busy reads 0)
      if (next_r.st == S_STATUS)
         next_r.dev_low = next_r.stat_pwr ? ~ext_powered  // [R7]
                                          : (next_r.conv | next_r.copy);

      // Bus reset drops any link transfer in progress; a running conversion or copy keeps going
      if (lnk.bus_reset)
      begin
         next_r.st      = S_ROM_CMD;  // [R19]
         next_r.idx     = 7'h00;
         next_r.ph      = 2'h0;
         next_r.dev_low = 1'b0;
      end
   end

   // Registered state
   always_ff @(posedge core_clk)
   begin
      if (rst)
         r <= RESET_VAL;
      else
         r <= next_r;
   end

   assign lnk.dev_low = r.dev_low;
endmodule : thermo_sensor

/* File: rtl/thermo_master.sv */
`timescale 1ns/10ps
// ==========================================================
// Operation FIFO
// ==========================================================
module op_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } fifo_regs_t;

   fifo_regs_t r;
   fifo_regs_t next_r;

   assign in_ready  = (r.cnt != (AW + 1)'(DEPTH));
   assign out_valid = (r.cnt != '0);
   assign out_data  = r.mem[r.rp];

   // Pointer and count update; simultaneous push and pop keep count
   always_comb
   begin
      next_r = r;
      if (in_valid && in_ready)
      begin
         next_r.mem[r.wp] = in_data;
         next_r.wp        = r.wp + AW'(1);
      end
      if (out_valid && out_ready)
         next_r.rp = r.rp + AW'(1);
      next_r.cnt = r.cnt + (AW + 1)'(in_valid && in_ready)
                         - (AW + 1)'(out_valid && out_ready);
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         r <= '0;
      else
         r <= next_r;
   end
endmodule : op_fifo

// ==========================================================
// Bus master
// ==========================================================
module thermo_master #(
   parameter int WAIT_CYCLES = thermo_link_pkg::WAIT_CYCLES
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       in_valid,
   output logic            in_ready,
   input  wire logic [9:0] in_data,
   output logic            rd_valid,
   output logic      [7:0] rd_data,
   output logic            busy,
   thermo_link_if.master   lnk
);
   typedef enum logic [3:0] {
      H_IDLE  = 4'h1,
      H_RESET = 4'h2,
      H_XFER  = 4'h4,
      H_WAIT  = 4'h8
   } host_state_t;

   typedef struct packed {
      host_state_t st;
      logic        wr;
      logic [7:0]  sh;
      logic [2:0]  bitn;
      logic [2:0]  div;
      logic [24:0] wcnt;
      logic        spu;
      logic        rd_valid;
      logic [7:0]  rd_data;
   } host_regs_t;

   host_regs_t r;
   host_regs_t next_r;
   logic       op_valid;
   logic [9:0] op_data;
   logic       slot_en;
   logic [7:0] byte_done;

   op_fifo #(.WIDTH(10), .DEPTH(8)) u_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   (in_data),
      .out_valid (op_valid),
      .out_ready (r.st == H_IDLE),
      .out_data  (op_data)
   );

   // Slot pacing divider gives the device time to settle its reply
   assign slot_en           = (r.div == thermo_link_pkg::SLOT_DIV - 3'h1);
   assign lnk.slot          = (r.st == H_XFER) && slot_en;
   assign lnk.master_bit    = (r.wr && r.st == H_XFER) ? r.sh[0] : 1'b1;  // [R4]
   assign byte_done         = {lnk.line, r.sh[7:1]};  // [R4]
   assign lnk.bus_reset     = (r.st == H_RESET);
   assign lnk.strong_pullup = r.spu;
   assign rd_valid          = r.rd_valid;
   assign rd_data           = r.rd_data;
   assign busy              = (r.st != H_IDLE) || op_valid;

   always_comb
   begin
      next_r          = r;
      next_r.rd_valid = 1'b0;
      next_r.div      = slot_en ? 3'h0 : r.div + 3'h1;
      case (r.st)
         H_IDLE:
         begin
            if (op_valid)
            begin
               // Any new op except a wait ends a held pullup [R8]
               next_r.spu  = 1'b0;
               next_r.sh   = op_data[7:0];
               next_r.bitn = 3'h0;
               next_r.div  = 3'h0;
               next_r.wr   = (op_data[9:8] == thermo_link_pkg::OP_WRITE);
               if (op_data[9:8] == thermo_link_pkg::OP_RESET)
                  next_r.st = H_RESET;
               else if (op_data[9:8] == thermo_link_pkg::OP_WAIT)
               begin
                  // Wait keeps a pullup already on
                  next_r.spu  = r.spu;
                  next_r.st   = H_WAIT;
                  next_r.wcnt = 25'(op_data[7:0] * WAIT_CYCLES);
               end
               else
                  next_r.st = H_XFER;  // [R2] [R6]
            end
         end
         H_RESET:
            next_r.st = H_IDLE;
         H_XFER:
         begin
            if (slot_en)
            begin
               next_r.sh   = byte_done;  // [R4]
               next_r.bitn = r.bitn + 3'h1;
               if (r.bitn == 3'h7)
               begin
                  next_r.st = H_IDLE;
                  // Pullup the cycle after a convert or copy byte [R5] [R8]
                  next_r.spu = r.wr && (byte_done == thermo_link_pkg::CMD_CONVERT ||
                                        byte_done == thermo_link_pkg::CMD_COPY);  // [R17]
                  if (!r.wr)
                  begin
                     next_r.rd_valid = 1'b1;
                     next_r.rd_data  = byte_done;
                  end
               end
            end
         end
         H_WAIT:
         begin
            next_r.wcnt = r.wcnt - 25'h0000001;
            if (r.wcnt == 25'h0000000)
               next_r.st = H_IDLE;
         end
         default:
            next_r.st = H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         r <= '{st: H_IDLE, default: '0};
      else
         r <= next_r;
   end
endmodule : thermo_master

/* File: bench/thermo_link_monitor.sv */
`timescale 1ns/10ps
// ==========
// Link checks
module thermo_link_monitor (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic bus_reset,
   input wire logic slot,
   input wire logic master_bit,
   input wire logic strong_pullup,
   input wire logic dev_low,
   input wire logic line
);
   logic [7:0] sh;
   logic [7:0] first;
   logic [7:0] second;
   logic [6:0] nb;
   logic [7:0] cur;
   logic       id_ok;
   logic       fn_ok;

   // Byte completed at this slot, first bit in the lowest place
   assign cur   = {line, sh[7:1]};
   assign id_ok = cur inside {[thermo_link_pkg::ROM_READ:thermo_link_pkg::ROM_ALARM]};
   assign fn_ok = cur inside {8'h44, 8'hBE, 8'h4E, 8'h48, thermo_link_pkg::CMD_RECALL,
                              thermo_link_pkg::CMD_POWER};

   // No reset: only whole bytes are ever judged
   always_ff @(posedge core_clk)
   begin
      if (slot)
         sh <= cur;
   end

   // Bit count and first two bytes since the last bus reset
   always_ff @(posedge core_clk)
   begin
      if (rst || bus_reset)
      begin
         nb     <= 7'h00;
         first  <= 8'h00;
         second <= 8'h00;
      end
      else if (slot)
      begin
         nb     <= (nb == 7'h7F) ? nb : nb + 7'h01;
         first  <= (nb == 7'h07) ? cur : first;
         second <= (nb == 7'h0F) ? cur : second;
      end
   end

   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // Ends of the identity byte and of the function byte after a bypass
   sequence id_end;
      slot && nb == 7'h07;
   endsequence
   sequence fn_end;
      slot && nb == 7'h0F && first == thermo_link_pkg::ROM_SKIP;
   endsequence

   pullup_after_cmd_a: assert property (fn_end ##0 (cur == 8'h44 || cur == 8'h48)
      |=> strong_pullup) else $error("no strong pullup after convert or copy");
   pullup_held_a: assert property (fn_end ##0 cur == 8'h44 |=> strong_pullup [*8])
      else $error("strong pullup dropped during conversion");
   reset_quiet_a: assert property (bus_reset |=> !dev_low [*3])
      else $error("sensor drives line after bus reset");
   locked_before_id_a: assert property (id_end ##0 !id_ok |=> !dev_low [*8])
      else $error("sensor answers without identity sequence");
   halt_unknown_a: assert property (fn_end ##0 !fn_ok |=> !dev_low [*8])
      else $error("sensor answers after unknown command");
   cmd_listen_a: assert property (slot && nb < 7'h08 |-> !dev_low)
      else $error("sensor drives line during identity byte");
   rom_bits_a: assert property (slot && master_bit && first == thermo_link_pkg::ROM_READ
      && nb >= 7'h08 && nb < 7'h48 |-> line == thermo_link_pkg::ROM_ID[6'(nb - 7'h08)])
      else $error("identity bit out of order");
   pad_tail_a: assert property (slot && master_bit && second == 8'hBE && nb >= 7'h38
      |-> line) else $error("scratchpad tail not released");
endmodule : thermo_link_monitor

/* File: bench/testbench.sv */
`timescale 1ns/10ps
`define CHECK(a, b) \
begin \
   compares++; \
   if ((a) !== (b)) \
   begin \
      error_cnt++; \
      $display("unexpected at %0t: %h vs %h", $time, a, b); \
   end \
end
// ==========
// Bench top
module testbench;
   logic        core_clk    = 1'b0;
   logic        rst         = 1'b1;
   logic        in_valid    = 1'b0;
   logic [9:0]  in_data     = 10'h000;
   logic        ext_powered = 1'b0;
   logic [15:0] temp_sample = 16'h0197;
   logic        full_seen   = 1'b0;
   logic        in_ready;
   logic        rd_valid;
   logic        m_busy;
   logic        s_busy;
   logic        alarm;
   logic [7:0]  rd_data;
   logic [7:0]  got[$];
   logic [7:0]  exp[$];
   int          error_cnt   = 0;
   int          compares    = 0;

   thermo_link_if lnk ();
   thermo_master #(.WAIT_CYCLES(4)) thermo_master_i (.core_clk(core_clk), .rst(rst),
      .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .rd_valid(rd_valid),
      .rd_data(rd_data), .busy(m_busy), .lnk(lnk));
   thermo_sensor #(.CONV_CYCLES(64), .COPY_CYCLES(16)) thermo_sensor_i (.core_clk(core_clk),
      .rst(rst), .ext_powered(ext_powered), .temp_sample(temp_sample), .alarm(alarm),
      .busy(s_busy), .lnk(lnk));
   thermo_link_monitor thermo_link_monitor_i (.core_clk(core_clk), .rst(rst),
      .bus_reset(lnk.bus_reset), .slot(lnk.slot), .master_bit(lnk.master_bit),
      .strong_pullup(lnk.strong_pullup), .dev_low(lnk.dev_low), .line(lnk.line));

   // Clock of 8 ns
   always #4 core_clk = ~core_clk;

   // Collect read bytes; note when the op queue refuses
   always @(posedge core_clk)
   begin
      if (rd_valid === 1'b1)
         got.push_back(rd_data);
      if (in_ready === 1'b0)
         full_seen = 1'b1;
   end

   task conclude;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude

   // One edge; a hang counts as a mismatch
   task step(inout int n);
      @(posedge core_clk);
      n++;
      if (n > 5000)
      begin
         error_cnt++;
         conclude();
      end
   endtask : step

   // Valid stays up between pushes so it is never set twice in one step
   task push(input logic [1:0] op, input logic [7:0] d);
      int n;
      n = 0;
      in_valid <= 1'b1;
      in_data  <= {op, d};
      step(n);
      while (in_ready !== 1'b1)
         step(n);
   endtask : push

   task w(input logic [7:0] d);
      push(thermo_link_pkg::OP_WRITE, d);
   endtask : w

   task rd(input int k);
      repeat (k) push(thermo_link_pkg::OP_READ, 8'h00);
   endtask : rd

   task cmd(input logic [7:0] f);
      push(thermo_link_pkg::OP_RESET, 8'h00);
      w(thermo_link_pkg::ROM_SKIP);
      w(f);
   endtask : cmd

   // Drain the master, then compare the read bytes
   task done;
      int n;
      n = 0;
      in_valid <= 1'b0;
      step(n);
      while (m_busy !== 1'b0)
         step(n);
      repeat (2) step(n);
      `CHECK(got.size(), exp.size())
      foreach (exp[i])
         `CHECK(got[i], exp[i])
      got.delete();
      exp.delete();
   endtask : done

   // Main sequence
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      cmd(8'hBE);
      rd(9);
      exp = '{8'h50, 8'h05, 8'h7F, 8'h80, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
      done();
      `CHECK(full_seen, 1'b1)
      push(thermo_link_pkg::OP_RESET, 8'h00);
      w(thermo_link_pkg::ROM_READ);
      rd(8);
      for (int i = 0; i < 8; i++)
         exp.push_back(thermo_link_pkg::ROM_ID[8*i +: 8]);
      done();
      cmd(8'h4E);
      w(8'h10);
      w(8'hF0);
      w(8'h1F);
      done();
      `CHECK(alarm, 1'b0)
      cmd(8'h44);
      push(thermo_link_pkg::OP_WAIT, 8'h40);
      done();
      `CHECK(alarm, 1'b1)
      `CHECK(s_busy, 1'b0)
      cmd(8'hBE);
      rd(5);
      exp = '{8'h90, 8'h01, 8'h10, 8'hF0, 8'h1F};
      done();
      cmd(8'h48);
      push(thermo_link_pkg::OP_WAIT, 8'h10);
      cmd(8'h4E);
      w(8'h7F);
      w(8'h80);
      w(8'h7F);
      cmd(thermo_link_pkg::CMD_RECALL);
      push(thermo_link_pkg::OP_WAIT, 8'h04);
      cmd(8'hBE);
      rd(5);
      exp = '{8'h90, 8'h01, 8'h10, 8'hF0, 8'h1F};
      done();
      for (int p = 0; p < 2; p++)
      begin
         ext_powered <= p[0];
         cmd(thermo_link_pkg::CMD_POWER);
         rd(1);
         exp.push_back({8{p[0]}});
         done();
      end
      cmd(8'h55);
      rd(1);
      exp.push_back(8'hFF);
      done();
      push(thermo_link_pkg::OP_RESET, 8'h00);
      w(8'hBE);
      rd(1);
      exp.push_back(8'hFF);
      done();
      cmd(8'hBE);
      rd(1);
      cmd(8'hBE);
      rd(1);
      exp = '{8'h90, 8'h90};
      done();
      push(thermo_link_pkg::OP_RESET, 8'h00);
      w(thermo_link_pkg::ROM_MATCH);
      for (int i = 0; i < 8; i++)
         w(thermo_link_pkg::ROM_ID[8*i +: 8]);
      w(8'hBE);
      rd(1);
      exp.push_back(8'h90);
      done();
      conclude();
   end
endmodule : testbench
